// ==== rir_reset_init.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rir_map.svh"
module rir_reset_init (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic                      power_on_reset_in_n,
  input  wire logic                      agent_mode,
  input  wire logic                      clkin_in,
  input  wire logic                      pci_clk_in,
  input  wire logic                      pci_sync_in,
  input  wire logic [`RIR_SRC_W-1:0]     cfg_rst_src_in,
  input  wire logic                      cfg_clkin_div_in,
  input  wire logic                      hard_reset_io_i_n,
  input  wire logic                      soft_reset_io_i_n,
  output logic                           hard_reset_io_o,
  output logic                           hard_reset_io_oe,
  output logic                           soft_reset_io_o,
  output logic                           soft_reset_io_oe,
  output logic                           quiet_state_out,
  output logic                           main_clk_sel_pci,
  output var rir_pkg::rir_cfg_s          cfg_out
);
  // ---------------------------------------------------------------
  // reference ticks
  // ---------------------------------------------------------------
  logic                  clkin_q_ff;
  logic                  pci_q_ff;
  logic                  sync_q_ff;
  logic                  sync_tick;
  logic                  main_tick;
  logic                  por_q_ff;
  logic                  por_fall;
  rir_pkg::rir_state_e   state_ff;
  rir_pkg::rir_state_e   nxt_state;
  logic [`RIR_CNT_W-1:0] cnt_ff;
  logic [`RIR_CNT_W-1:0] hold_ticks_ff;
  logic                  hard_seen;
  logic                  soft_seen;
  logic                  idle;

  // previous samples for rising edge detection
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      clkin_q_ff <= 1'b0;
      pci_q_ff   <= 1'b0;
      sync_q_ff  <= 1'b0;
      por_q_ff   <= 1'b0;
    end else begin
      clkin_q_ff <= clkin_in;
      pci_q_ff   <= pci_clk_in;
      sync_q_ff  <= pci_sync_in;
      por_q_ff   <= power_on_reset_in_n;
    end
  end

  assign sync_tick = pci_sync_in && !sync_q_ff;
  assign por_fall  = power_on_reset_in_n && !por_q_ff; // negation
  // main clock source follows the captured mode
  assign main_tick = cfg_out.agent ? (pci_clk_in && !pci_q_ff)
                                   : (clkin_in && !clkin_q_ff);
  assign idle      = state_ff == rir_pkg::RIR_IDLE;

  // ---------------------------------------------------------------
  // power-on configuration
  // ---------------------------------------------------------------
  // capture on negation, hold until the next power-on reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfg_out <= '0;
    end else if (por_fall) begin
      cfg_out.rst_src   <= cfg_rst_src_in;
      cfg_out.clkin_div <= cfg_clkin_div_in;
      cfg_out.agent     <= agent_mode;
    end
  end

  // main clock select flag
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      main_clk_sel_pci <= 1'b0;
    end else begin
      main_clk_sel_pci <= cfg_out.agent;
    end
  end

  // ---------------------------------------------------------------
  // input length filters
  // ---------------------------------------------------------------
  rir_len_filter #(.MIN_TICKS(`RIR_IN_MIN_TICKS)) u_hard_flt (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tick    (sync_tick),
    .enable  (idle),
    .pin_n   (hard_reset_io_i_n),
    .seen    (hard_seen)
  );

  rir_len_filter #(.MIN_TICKS(`RIR_IN_MIN_TICKS)) u_soft_flt (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tick    (sync_tick),
    .enable  (idle),
    .pin_n   (soft_reset_io_i_n),
    .seen    (soft_seen)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // next state; power-on reset overrides everything
  always_comb begin
    nxt_state = state_ff;
    if (!power_on_reset_in_n) begin
      nxt_state = rir_pkg::RIR_POR_HOLD;
    end else begin
      unique case (state_ff)
        rir_pkg::RIR_IDLE: begin
          if (hard_seen) begin
            nxt_state = rir_pkg::RIR_BOTH;
          end else if (soft_seen) begin
            nxt_state = rir_pkg::RIR_SOFT_ONLY;
          end
        end
        rir_pkg::RIR_POR_HOLD: nxt_state = rir_pkg::RIR_BOTH;
        rir_pkg::RIR_BOTH: begin
          if (sync_tick && cnt_ff == `RIR_CNT_W'(`RIR_OUT_MIN_TICKS - 1)) begin
            nxt_state = rir_pkg::RIR_GAP;
          end
        end
        rir_pkg::RIR_GAP: begin
          if (sync_tick && cnt_ff == `RIR_CNT_W'(`RIR_NEG_GAP_TICKS - 1)) begin
            nxt_state = rir_pkg::RIR_IDLE;
          end
        end
        rir_pkg::RIR_SOFT_ONLY: begin
          if (sync_tick && cnt_ff == `RIR_CNT_W'(`RIR_OUT_MIN_TICKS - 1)) begin
            nxt_state = rir_pkg::RIR_IDLE;
          end
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_ff <= rir_pkg::RIR_POR_HOLD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // tick counter, cleared on every state change
  always_ff @(posedge ref_clk) begin
    if (!rst_n || nxt_state != state_ff) begin
      cnt_ff <= '0;
    end else if (sync_tick) begin
      cnt_ff <= cnt_ff + `RIR_CNT_W'(1);
    end
  end

  // sync ticks seen while hard reset is driven, saturating; the
  // release check counts on its own so a counter fault shows up
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !hard_reset_io_oe) begin
      hold_ticks_ff <= '0;
    end else if (sync_tick && hold_ticks_ff != '1) begin
      hold_ticks_ff <= hold_ticks_ff + `RIR_CNT_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // open-drain pins and status
  // ---------------------------------------------------------------
  // data is always low; enable alone pulls the pin
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hard_reset_io_o  <= 1'b0;
      soft_reset_io_o  <= 1'b0;
      hard_reset_io_oe <= 1'b1;
      soft_reset_io_oe <= 1'b1;
      quiet_state_out  <= 1'b1;
    end else begin
      hard_reset_io_o  <= 1'b0;
      soft_reset_io_o  <= 1'b0;
      hard_reset_io_oe <= nxt_state == rir_pkg::RIR_POR_HOLD ||
                          nxt_state == rir_pkg::RIR_BOTH;
      soft_reset_io_oe <= nxt_state != rir_pkg::RIR_IDLE;
      quiet_state_out  <= nxt_state != rir_pkg::RIR_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_pins_open_drain: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !hard_reset_io_o && !soft_reset_io_o)
    else $error("reset pin driven high");

  chk_hard_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(hard_reset_io_oe) |-> soft_reset_io_oe)
    else $error("hard reset released after soft reset");

  chk_both_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(hard_reset_io_oe)
    |-> hold_ticks_ff >= `RIR_CNT_W'(`RIR_OUT_MIN_TICKS))
    else $error("reset outputs released early");

  chk_gap_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_ff == rir_pkg::RIR_GAP && nxt_state == rir_pkg::RIR_IDLE
    && power_on_reset_in_n
    |-> cnt_ff == `RIR_CNT_W'(`RIR_NEG_GAP_TICKS - 1))
    else $error("soft reset released too soon after hard");

  chk_flow_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    idle && power_on_reset_in_n && !hard_seen && !soft_seen
    |=> state_ff == rir_pkg::RIR_IDLE)
    else $error("reset flow started without qualified input");

  chk_cfg_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !por_fall |=> $stable(cfg_out))
    else $error("configuration changed outside power-on negation");

  chk_main_clk: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $stable(cfg_out.agent) |-> main_clk_sel_pci == cfg_out.agent)
    else $error("main clock select does not follow mode");
endmodule : rir_reset_init
`default_nettype wire

// ==== rir_map.svh ====
`ifndef RIR_MAP_SVH
`define RIR_MAP_SVH
// ---------------------------------------------------------------
// reset sequencing counts, in rising edges of pci_sync_in, and field widths
// ---------------------------------------------------------------
`define RIR_IN_MIN_TICKS    32
`define RIR_OUT_MIN_TICKS   512
`define RIR_NEG_GAP_TICKS   16
`define RIR_CNT_W           10
`define RIR_SRC_W           3
`endif

// ==== rir_pkg.sv ====
`default_nettype none
package rir_pkg;
  // sequencer states
  typedef enum logic [2:0] {
    RIR_IDLE,
    RIR_POR_HOLD,
    RIR_BOTH,
    RIR_GAP,
    RIR_SOFT_ONLY
  } rir_state_e;

  // power-on configuration captured at power-on reset negation
  typedef struct packed {
    logic [2:0] rst_src;
    logic       clkin_div;
    logic       agent;
  } rir_cfg_s;
endpackage : rir_pkg
`default_nettype wire

// ==== rir_len_filter.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rir_map.svh"
// ---------------------------------------------------------------
// assertion length filter for one active low reset input
// ---------------------------------------------------------------
module rir_len_filter #(
  parameter int unsigned MIN_TICKS = `RIR_IN_MIN_TICKS
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic tick,
  input  wire logic enable,
  input  wire logic pin_n,
  output logic      seen
);
  logic [5:0] len_ff;

  // count reference ticks while the pin stays low, saturate at limit
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !enable || pin_n) begin
      len_ff <= 6'h00;
    end else if (tick && len_ff != 6'(MIN_TICKS)) begin
      len_ff <= len_ff + 6'h01;
    end
  end

  // one pulse when the assertion reaches the required length
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      seen <= 1'b0;
    end else begin
      seen <= enable && !pin_n && tick &&
              len_ff == 6'(MIN_TICKS - 1);
    end
  end

  chk_len_reached: assert property (@(posedge ref_clk) disable iff (!rst_n)
    seen |-> $past(len_ff) == 6'(MIN_TICKS - 1))
    else $error("reset input accepted before full length");
endmodule : rir_len_filter
`default_nettype wire

// ==== rir_board_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// board model: clock sources and pulled-up reset wires
// ---------------------------------------------------------------
module rir_board_model #(
  parameter int P = 4
) (
  input  wire logic ref_clk,
  input  wire logic hard_pull,
  input  wire logic soft_pull,
  input  wire logic hard_oe,
  input  wire logic soft_oe,
  output logic      clkin_in,
  output logic      pci_clk_in,
  output logic      pci_sync_in,
  output logic      hard_lvl_n,
  output logic      soft_lvl_n
);
  int ph = 0;

  // stable free running clocks, stepped off the sampling edge
  always @(negedge ref_clk) begin
    ph <= (ph + 1) % P;
  end
  assign pci_sync_in = (ph >= P / 2);
  assign clkin_in    = (ph >= P / 2);
  assign pci_clk_in  = (ph < P / 2);

  // wired low with pull-up: released wire reads high
  assign hard_lvl_n = !(hard_pull || hard_oe);
  assign soft_lvl_n = !(soft_pull || soft_oe);
endmodule : rir_board_model
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  err_total++; $display("CHECK FAILED at %0t: got %0h exp %0h", \
  $time, g, e); end end
module testbench;
  localparam int P = 4;
  logic              ref_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              por_n = 1'b0;
  logic              agent = 1'b0;
  logic [2:0]        src = 3'h0;
  logic              div = 1'b0;
  logic              hard_pull = 1'b0;
  logic              soft_pull = 1'b0;
  logic              clkin, pci_clk, sync, hard_n, soft_n;
  logic              h_o, h_oe, s_o, s_oe, quiet, sel;
  rir_pkg::rir_cfg_s cfg;
  int                err_total = 0;
  int                checks_done = 0;
  int                hc, sc, hl, sl, qc;

  // ---------------------------------------------------------------
  // clock, board and design
  // ---------------------------------------------------------------
  always #4 ref_clk = ~ref_clk;

  rir_board_model #(.P(P)) board (.ref_clk(ref_clk),
    .hard_pull(hard_pull), .soft_pull(soft_pull), .hard_oe(h_oe),
    .soft_oe(s_oe), .clkin_in(clkin), .pci_clk_in(pci_clk),
    .pci_sync_in(sync), .hard_lvl_n(hard_n), .soft_lvl_n(soft_n));

  rir_reset_init uut (.ref_clk(ref_clk), .rst_n(rst_n),
    .power_on_reset_in_n(por_n), .agent_mode(agent), .clkin_in(clkin),
    .pci_clk_in(pci_clk), .pci_sync_in(sync), .cfg_rst_src_in(src),
    .cfg_clkin_div_in(div), .hard_reset_io_i_n(hard_n),
    .soft_reset_io_i_n(soft_n), .hard_reset_io_o(h_o),
    .hard_reset_io_oe(h_oe), .soft_reset_io_o(s_o),
    .soft_reset_io_oe(s_oe), .quiet_state_out(quiet),
    .main_clk_sel_pci(sel), .cfg_out(cfg));

  // pins may only ever be pulled low, looked at once settled
  always @(negedge ref_clk) begin
    if (rst_n) `CHK({h_o, s_o}, 2'b00)
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  // mode 0: no flow, 1: soft only, 2: hard then soft
  task automatic run_flow(input logic hp, input logic sp, input int len,
                          input int mode);
    int es;
    es = (mode == 2) ? 528 * P : 512 * P;
    hc = 0;
    sc = 0;
    qc = 0;
    hl = 0;
    sl = 0;
    for (int i = 1; i < 600 * P; i++) begin
      @(negedge ref_clk);
      hard_pull = hp && (i <= len);
      soft_pull = sp && (i <= len);
      if (h_oe === 1'b1) begin hc++; hl = i; end
      if (s_oe === 1'b1) begin sc++; sl = i; end
      if (quiet === 1'b1) qc++;
    end
    if (mode == 0) begin
      `CHK(hc + sc + qc, 0)
    end else begin
      `CHK(sc >= es - P && sc <= es + 3 * P, 1'b1)
      `CHK(qc >= es - P && qc <= es + 3 * P, 1'b1)
      if (mode == 1) `CHK(hc, 0)
      else `CHK(hc >= 511 * P && hc <= 515 * P, 1'b1)
      if (mode == 2) `CHK(sl - hl >= 15 * P && sl - hl <= 17 * P, 1'b1)
    end
  endtask : run_flow

  task automatic por_cycle(input logic a);
    rir_pkg::rir_cfg_s exp;
    @(negedge ref_clk);
    por_n = 1'b0;
    agent = a;
    src = 3'($urandom);
    div = 1'($urandom);
    exp = '{rst_src: src, clkin_div: div, agent: a};
    repeat (40 * P) @(negedge ref_clk);
    `CHK({h_oe, s_oe}, 2'b11)
    por_n = 1'b1;
    run_flow(1'b0, 1'b0, 0, 2);
    `CHK(cfg, exp)
    `CHK(sel, a)
    src = ~src;
    div = ~div;
    agent = ~a;
    repeat (4) @(negedge ref_clk);
    `CHK(cfg, exp)
  endtask : por_cycle

  task automatic report_and_stop;
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'hE8746D90));
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    por_cycle(1'b0);
    por_cycle(1'b1);
    run_flow(1'b1, 1'b0, 31 * P - 1, 0);
    run_flow(1'b1, 1'b1, 33 * P, 2);
    run_flow(1'b0, 1'b1, 33 * P, 1);
    report_and_stop();
  end

  initial begin
    repeat (30000) @(posedge ref_clk);
    err_total++;
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
